// [rtl/iolpm_mux.sv]
// Top: peripheral multiplexing for I/O controllers A and B
`timescale 1ns/1ps
module iolpm_mux #(
    parameter logic [31:0] PERIPH_RESET_A = iolpm_pkg::PERIPH_RESET_A,
    parameter logic [31:0] PERIPH_RESET_B = iolpm_pkg::PERIPH_RESET_B
) (
    input wire logic clk,
    input wire logic rst_b,
    // Configuration from the controller's own register side
    input wire logic [31:0] cfg_periph_set_a,
    input wire logic [31:0] cfg_periph_clr_a,
    input wire logic [31:0] cfg_sel_b_a,
    input wire logic [31:0] cfg_pullup_a,
    input wire logic [31:0] cfg_periph_set_b,
    input wire logic [31:0] cfg_periph_clr_b,
    input wire logic [31:0] cfg_sel_b_b,
    input wire logic [31:0] cfg_pullup_b,
    // Plain I/O drive
    input wire logic [31:0] gp_out_a,
    input wire logic [31:0] gp_oe_a,
    input wire logic [31:0] gp_out_b,
    input wire logic [31:0] gp_oe_b,
    // Peripheral sources
    input wire logic [31:0] func_a_out_a,
    input wire logic [31:0] func_a_oe_a,
    input wire logic [31:0] func_b_out_a,
    input wire logic [31:0] func_b_oe_a,
    input wire logic [31:0] func_a_out_b,
    input wire logic [31:0] func_a_oe_b,
    input wire logic [31:0] func_b_out_b,
    input wire logic [31:0] func_b_oe_b,
    // Pins
    input wire logic [31:0] pin_in_a,
    input wire logic [31:0] pin_in_b,
    output logic [31:0] pin_out_a,
    output logic [31:0] pin_oe_a,
    output logic [31:0] pin_pullup_a,
    output logic [31:0] pin_out_b,
    output logic [31:0] pin_oe_b,
    output logic [31:0] pin_pullup_b,
    // Inputs returned to peripherals and plain I/O
    output logic [31:0] func_a_in_a,
    output logic [31:0] func_b_in_a,
    output logic [31:0] gp_in_a,
    output logic [31:0] func_a_in_b,
    output logic [31:0] func_b_in_b,
    output logic [31:0] gp_in_b,
    // Named taps of the pin map
    output logic serial_port0_master_in,
    output logic card_slot_b_data0,
    output logic debug_serial_rx,
    // Status
    output logic [31:0] peripheral_select_status_a,
    output logic [31:0] peripheral_select_status_b
);
    // ------------------------------------------------------------
    // Per-line mode state
    // ------------------------------------------------------------
    logic [31:0] psel_a_reg;
    logic [31:0] psel_b_reg;
    logic [31:0] selb_a_reg;
    logic [31:0] selb_b_reg;
    logic [31:0] pu_a_reg;
    logic [31:0] pu_b_reg;
    wire [31:0] psel_a_next;
    wire [31:0] psel_b_next;

    // Set wins over clear when both name a line in one cycle
    function automatic logic [31:0] iolpm_setclr(input logic [31:0] cur,
        input logic [31:0] set, input logic [31:0] clr);
        iolpm_setclr = (cur & ~clr) | set;
    endfunction : iolpm_setclr

    assign psel_a_next = iolpm_setclr(psel_a_reg, cfg_periph_set_a, cfg_periph_clr_a);
    assign psel_b_next = iolpm_setclr(psel_b_reg, cfg_periph_set_b, cfg_periph_clr_b);

    // Controller A mode bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            psel_a_reg <= PERIPH_RESET_A;
            selb_a_reg <= iolpm_pkg::SELB_RESET;
            pu_a_reg <= iolpm_pkg::PULLUP_RESET;
        end else begin
            psel_a_reg <= psel_a_next;
            selb_a_reg <= cfg_sel_b_a;
            pu_a_reg <= cfg_pullup_a;
        end
    end

    // Controller B mode bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            psel_b_reg <= PERIPH_RESET_B;
            selb_b_reg <= iolpm_pkg::SELB_RESET;
            pu_b_reg <= iolpm_pkg::PULLUP_RESET;
        end else begin
            psel_b_reg <= psel_b_next;
            selb_b_reg <= cfg_sel_b_b;
            pu_b_reg <= cfg_pullup_b;
        end
    end

    // ------------------------------------------------------------
    // Line slices
    // ------------------------------------------------------------
    iolpm_line_if #(.N(iolpm_pkg::LINES)) lif_a ();
    iolpm_line_if #(.N(iolpm_pkg::LINES)) lif_b ();

    assign lif_a.periph_sel = psel_a_reg;
    assign lif_a.sel_b = selb_a_reg;
    assign lif_a.b_present = iolpm_pkg::FUNC_B_PRESENT_A;
    assign lif_a.gp_out = gp_out_a;
    assign lif_a.gp_oe = gp_oe_a;
    assign lif_a.a_out = func_a_out_a;
    assign lif_a.a_oe = func_a_oe_a;
    assign lif_a.b_out = func_b_out_a;
    assign lif_a.b_oe = func_b_oe_a;
    assign lif_a.pin_in = pin_in_a;

    assign lif_b.periph_sel = psel_b_reg;
    assign lif_b.sel_b = selb_b_reg;
    assign lif_b.b_present = iolpm_pkg::FUNC_B_PRESENT_B;
    assign lif_b.gp_out = gp_out_b;
    assign lif_b.gp_oe = gp_oe_b;
    assign lif_b.a_out = func_a_out_b;
    assign lif_b.a_oe = func_a_oe_b;
    assign lif_b.b_out = func_b_out_b;
    assign lif_b.b_oe = func_b_oe_b;
    assign lif_b.pin_in = pin_in_b;

    iolpm_line_slice u_slice_a (.lif(lif_a));
    iolpm_line_slice u_slice_b (.lif(lif_b));

    // ------------------------------------------------------------
    // Pin-map taps
    // ------------------------------------------------------------
    // Taps use the gated returns: a peripheral sees no pin activity while its line is plain I/O
    wire miso_tap_next;
    wire card_b0_tap_next;
    wire debug_rx_tap_next;

    assign miso_tap_next = lif_a.a_in_next[iolpm_pkg::LINE_SERIAL0_MISO];
    assign card_b0_tap_next = lif_a.b_in_next[iolpm_pkg::LINE_SERIAL0_MISO];
    assign debug_rx_tap_next = lif_b.a_in_next[iolpm_pkg::LINE_DEBUG_RX];

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Pad drive is registered so it never glitches while the mode bits settle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_a <= iolpm_pkg::OUT_RESET;
            pin_oe_a <= iolpm_pkg::OE_RESET;
            pin_pullup_a <= iolpm_pkg::PULLUP_RESET;
        end else begin
            pin_out_a <= lif_a.pin_out_next;
            pin_oe_a <= lif_a.pin_oe_next;
            pin_pullup_a <= pu_a_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_b <= iolpm_pkg::OUT_RESET;
            pin_oe_b <= iolpm_pkg::OE_RESET;
            pin_pullup_b <= iolpm_pkg::PULLUP_RESET;
        end else begin
            pin_out_b <= lif_b.pin_out_next;
            pin_oe_b <= lif_b.pin_oe_next;
            pin_pullup_b <= pu_b_reg;
        end
    end

    // Returns to the peripherals and to plain I/O
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            func_a_in_a <= iolpm_pkg::OUT_RESET;
            func_b_in_a <= iolpm_pkg::OUT_RESET;
            gp_in_a <= iolpm_pkg::OUT_RESET;
        end else begin
            func_a_in_a <= lif_a.a_in_next;
            func_b_in_a <= lif_a.b_in_next;
            gp_in_a <= lif_a.gp_in_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            func_a_in_b <= iolpm_pkg::OUT_RESET;
            func_b_in_b <= iolpm_pkg::OUT_RESET;
            gp_in_b <= iolpm_pkg::OUT_RESET;
        end else begin
            func_a_in_b <= lif_b.a_in_next;
            func_b_in_b <= lif_b.b_in_next;
            gp_in_b <= lif_b.gp_in_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_port0_master_in <= 1'b0;
            card_slot_b_data0 <= 1'b0;
            debug_serial_rx <= 1'b0;
        end else begin
            serial_port0_master_in <= miso_tap_next;
            card_slot_b_data0 <= card_b0_tap_next;
            debug_serial_rx <= debug_rx_tap_next;
        end
    end

    // Status lags the mode register by one edge, in step with the pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            peripheral_select_status_a <= PERIPH_RESET_A;
            peripheral_select_status_b <= PERIPH_RESET_B;
        end else begin
            peripheral_select_status_a <= psel_a_reg;
            peripheral_select_status_b <= psel_b_reg;
        end
    end
endmodule : iolpm_mux

// [rtl/iolpm_pkg.sv]
// Package: constants for the I/O line peripheral multiplexer
package iolpm_pkg;
    localparam int LINES = 32;
    localparam int CTRL_COUNT = 2;
    localparam int CTRL_A = 0;
    localparam int CTRL_B = 1;
    // Mode per line: 2 bits
    localparam logic [1:0] MODE_IO = 2'h0;
    localparam logic [1:0] MODE_FUNC_A = 2'h1;
    localparam logic [1:0] MODE_FUNC_B = 2'h2;
    // Reset: every line of both controllers in I/O mode
    localparam logic [31:0] PERIPH_RESET_A = 32'h0000_0000;
    localparam logic [31:0] PERIPH_RESET_B = 32'h0000_0000;
    localparam logic [31:0] SELB_RESET = 32'h0000_0000;
    localparam logic [31:0] PULLUP_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] OUT_RESET = 32'h0000_0000;
    localparam logic [31:0] OE_RESET = 32'h0000_0000;
    // Lines named in the pin map
    localparam int LINE_SERIAL0_MISO = 0;
    localparam int LINE_DEBUG_RX = 14;
    // Function B presence masks of both controllers (controller B line 14 has none)
    localparam logic [31:0] FUNC_B_PRESENT_B = 32'hFFFF_BFFF;
    localparam logic [31:0] FUNC_B_PRESENT_A = 32'hFFFF_FFFF;
endpackage : iolpm_pkg

// [rtl/iolpm_line_if.sv]
// Interface: per-controller line bundle between top and line slice
`timescale 1ns/1ps
interface iolpm_line_if #(parameter int N = 32);
    logic [N-1:0] periph_sel;
    logic [N-1:0] sel_b;
    logic [N-1:0] b_present;
    logic [N-1:0] gp_out;
    logic [N-1:0] gp_oe;
    logic [N-1:0] a_out;
    logic [N-1:0] a_oe;
    logic [N-1:0] b_out;
    logic [N-1:0] b_oe;
    logic [N-1:0] pin_in;
    logic [N-1:0] pin_out_next;
    logic [N-1:0] pin_oe_next;
    logic [N-1:0] a_in_next;
    logic [N-1:0] b_in_next;
    logic [N-1:0] gp_in_next;
    modport ctrl (output periph_sel, sel_b, b_present, gp_out, gp_oe, a_out, a_oe, b_out, b_oe,
                  pin_in, input pin_out_next, pin_oe_next, a_in_next, b_in_next, gp_in_next);
    modport slice (input periph_sel, sel_b, b_present, gp_out, gp_oe, a_out, a_oe, b_out, b_oe,
                   pin_in, output pin_out_next, pin_oe_next, a_in_next, b_in_next, gp_in_next);
endinterface : iolpm_line_if

// [rtl/iolpm_line_slice.sv]
// Combinational mux of one controller's 32 lines
`timescale 1ns/1ps
module iolpm_line_slice (
    iolpm_line_if.slice lif
);
    wire [31:0] use_b;
    wire [31:0] use_a;

    assign use_b = lif.periph_sel & lif.sel_b & lif.b_present;
    assign use_a = lif.periph_sel & ~use_b;

    // An absent function B falls back to A so the pin is never left to an idle source
    assign lif.pin_out_next = (use_a & lif.a_out) | (use_b & lif.b_out)
                            | (~lif.periph_sel & lif.gp_out);
    assign lif.pin_oe_next = (use_a & lif.a_oe) | (use_b & lif.b_oe)
                           | (~lif.periph_sel & lif.gp_oe);
    assign lif.a_in_next = use_a & lif.pin_in;
    assign lif.b_in_next = use_b & lif.pin_in;
    assign lif.gp_in_next = lif.pin_in;
endmodule : iolpm_line_slice

// [bench/iolpm_partner.sv]
// Far side model: peripheral sources and pad levels
`timescale 1ns/1ps
module iolpm_partner (
    input wire logic clk,
    output logic [31:0] src_a,
    output logic [31:0] src_b,
    output logic [31:0] pads
);
    logic [31:0] cnt_reg = 32'h0;
    // New pattern every cycle, so a register that never updates is caught
    always @(negedge clk) begin
        cnt_reg <= cnt_reg + 32'h9E37_79B9;
    end
    assign src_a = cnt_reg;
    assign src_b = ~cnt_reg;
    assign pads = {cnt_reg[15:0], cnt_reg[31:16]};
endmodule : iolpm_partner

// [bench/iolpm_mux_checker.sv]
// Concurrent checks on controller A: line 0, with reset and pull-up checks over all 32 lines
`timescale 1ns/1ps
module iolpm_checker #(
    parameter logic [31:0] PERIPH_RESET_A = 32'h0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] cfg_periph_set_a,
    input wire logic [31:0] cfg_periph_clr_a,
    input wire logic [31:0] cfg_sel_b_a,
    input wire logic [31:0] cfg_pullup_a,
    input wire logic [31:0] gp_out_a,
    input wire logic [31:0] func_a_out_a,
    input wire logic [31:0] func_b_out_a,
    input wire logic [31:0] pin_in_a,
    input wire logic [31:0] pin_out_a,
    input wire logic [31:0] pin_oe_a,
    input wire logic [31:0] pin_pullup_a,
    input wire logic serial_port0_master_in,
    input wire logic [31:0] peripheral_select_status_a
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    set_status_a: assert property (
        cfg_periph_set_a[0] |-> ##2 peripheral_select_status_a[0])
        else $error("status not set two edges after set");
    clr_status_a: assert property (
        cfg_periph_clr_a[0] && !cfg_periph_set_a[0] |-> ##2 !peripheral_select_status_a[0])
        else $error("status not cleared");
    reset_status_a: assert property (
        $rose(rst_b) |-> peripheral_select_status_a == PERIPH_RESET_A)
        else $error("status wrong after reset");
    reset_pins_a: assert property (
        $rose(rst_b) |-> pin_oe_a == 32'h0 && pin_pullup_a == 32'hFFFF_FFFF)
        else $error("pins not input with pull-up after reset");
    route_fa_a: assert property (
        peripheral_select_status_a[0] && !$past(cfg_sel_b_a[0], 2) |->
        pin_out_a[0] == $past(func_a_out_a[0])) else $error("function A not routed");
    route_fb_a: assert property (
        peripheral_select_status_a[0] && $past(cfg_sel_b_a[0], 2) |->
        pin_out_a[0] == $past(func_b_out_a[0])) else $error("function B not routed");
    route_io_a: assert property (
        !peripheral_select_status_a[0] && $past(rst_b) |->
        pin_out_a[0] == $past(gp_out_a[0])) else $error("plain output not routed");
    pullup_track_a: assert property (
        $past(rst_b, 2) && $past(rst_b) |->
        pin_pullup_a == $past(cfg_pullup_a, 2)) else $error("pull-up does not follow");
    miso_tap_a: assert property (
        serial_port0_master_in == (peripheral_select_status_a[0] &&
        !$past(cfg_sel_b_a[0], 2) && $past(pin_in_a[0]))) else $error("tap mismatch");
    cover property (peripheral_select_status_a[0] && cfg_sel_b_a[0]);
    cover property ($fell(peripheral_select_status_a[0]));
    cover property (cfg_periph_set_a[0] && cfg_periph_clr_a[0]);
endmodule : iolpm_checker
bind iolpm_mux iolpm_checker #(.PERIPH_RESET_A(PERIPH_RESET_A)) u_chk (.clk, .rst_b,
    .cfg_periph_set_a, .cfg_periph_clr_a, .cfg_sel_b_a, .cfg_pullup_a, .gp_out_a, .func_a_out_a,
    .func_b_out_a, .pin_in_a, .pin_out_a, .pin_oe_a, .pin_pullup_a, .serial_port0_master_in,
    .peripheral_select_status_a);

// [bench/tb_io_line_peripheral_mux.sv]
// Self-checking bench for the I/O line peripheral multiplexer
`timescale 1ns/1ps
module tb_io_line_peripheral_mux;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] cfg_periph_set_a, cfg_periph_clr_a, cfg_sel_b_a, cfg_periph_set_b;
    logic [31:0] cfg_periph_clr_b, cfg_sel_b_b, cfg_pullup, gp_out, gp_oe, src_a, src_b, pads;
    logic [31:0] pin_out_a, pin_oe_a, pin_pullup_a, pin_out_b, pin_oe_b, pin_pullup_b;
    logic [31:0] func_a_in_a, func_b_in_a, gp_in_a, func_a_in_b, func_b_in_b, gp_in_b;
    logic [31:0] peripheral_select_status_a, peripheral_select_status_b;
    logic serial_port0_master_in, card_slot_b_data0, debug_serial_rx;
    logic [31:0] pre_status_a, pre_status_b, pre_oe_a, pre_pullup_a;
    // Lines of the second copy that come out of reset in a function
    localparam logic [31:0] PRESET_A = 32'h0000_0F00;
    localparam logic [31:0] PRESET_B = 32'h00F0_0000;
    int err_total = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    iolpm_partner u_far (.clk, .src_a, .src_b, .pads);
    iolpm_mux DUT (.clk, .rst_b, .cfg_periph_set_a, .cfg_periph_clr_a, .cfg_sel_b_a,
        .cfg_pullup_a(cfg_pullup), .cfg_periph_set_b, .cfg_periph_clr_b, .cfg_sel_b_b,
        .cfg_pullup_b(cfg_pullup), .gp_out_a(gp_out), .gp_oe_a(gp_oe), .gp_out_b(gp_out),
        .gp_oe_b(gp_oe), .func_a_out_a(src_a), .func_a_oe_a(src_b), .func_b_out_a(src_b),
        .func_b_oe_a(src_a), .func_a_out_b(src_a), .func_a_oe_b(src_b), .func_b_out_b(src_b),
        .func_b_oe_b(src_a), .pin_in_a(pads), .pin_in_b(pads), .pin_out_a, .pin_oe_a,
        .pin_pullup_a, .pin_out_b, .pin_oe_b, .pin_pullup_b, .func_a_in_a, .func_b_in_a, .gp_in_a,
        .func_a_in_b, .func_b_in_b, .gp_in_b, .serial_port0_master_in, .card_slot_b_data0,
        .debug_serial_rx, .peripheral_select_status_a, .peripheral_select_status_b);
    iolpm_mux #(.PERIPH_RESET_A(PRESET_A), .PERIPH_RESET_B(PRESET_B)) DUT_PRESET (.clk, .rst_b,
        .cfg_periph_set_a, .cfg_periph_clr_a, .cfg_sel_b_a, .cfg_pullup_a(cfg_pullup),
        .cfg_periph_set_b, .cfg_periph_clr_b, .cfg_sel_b_b, .cfg_pullup_b(cfg_pullup),
        .gp_out_a(gp_out), .gp_oe_a(gp_oe), .gp_out_b(gp_out), .gp_oe_b(gp_oe),
        .func_a_out_a(src_a), .func_a_oe_a(src_b), .func_b_out_a(src_b), .func_b_oe_a(src_a),
        .func_a_out_b(src_a), .func_a_oe_b(src_b), .func_b_out_b(src_b), .func_b_oe_b(src_a),
        .pin_in_a(pads), .pin_in_b(pads), .pin_out_a(), .pin_oe_a(pre_oe_a),
        .pin_pullup_a(pre_pullup_a), .pin_out_b(), .pin_oe_b(), .pin_pullup_b(), .func_a_in_a(),
        .func_b_in_a(), .gp_in_a(), .func_a_in_b(), .func_b_in_b(), .gp_in_b(),
        .serial_port0_master_in(), .card_slot_b_data0(), .debug_serial_rx(),
        .peripheral_select_status_a(pre_status_a), .peripheral_select_status_b(pre_status_b));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic check_reset();
        chk(peripheral_select_status_a | peripheral_select_status_b, 32'h0);
        chk(pin_oe_a | pin_oe_b, 32'h0);
        chk(pin_pullup_a & pin_pullup_b, 32'hFFFF_FFFF);
        chk(pre_status_a, PRESET_A);
        chk(pre_status_b, PRESET_B);
        chk(pre_pullup_a, 32'hFFFF_FFFF);
    endtask : check_reset
    // Two edges after release: preset lines drive at once, plain lines follow their settings
    task automatic check_release();
        logic [31:0] fn_oe;
        fn_oe = (cfg_sel_b_a & src_a) | (~cfg_sel_b_a & src_b);
        chk(pre_oe_a, (PRESET_A & fn_oe) | (~PRESET_A & gp_oe));
        chk(pin_pullup_a, cfg_pullup);
        chk(peripheral_select_status_a, 32'h0);
    endtask : check_release
    // Every line in a function; sel picks B per line, B line 14 must fall back to A
    task automatic run_route(input logic [31:0] sel);
        logic [31:0] sb;
        sb = sel & 32'hFFFF_BFFF;
        cfg_periph_set_a = 32'hFFFF_FFFF;
        cfg_periph_set_b = 32'hFFFF_FFFF;
        cfg_sel_b_a = sel;
        cfg_sel_b_b = sel;
        cyc(1);
        cfg_periph_set_a = 32'h0;
        cfg_periph_set_b = 32'h0;
        cyc(3);
        chk(peripheral_select_status_a, 32'hFFFF_FFFF);
        chk(peripheral_select_status_b, 32'hFFFF_FFFF);
        chk(pin_out_a, (sel & src_b) | (~sel & src_a));
        chk(pin_oe_a, (sel & src_a) | (~sel & src_b));
        chk(func_a_in_a, pads & ~sel);
        chk(func_b_in_a, pads & sel);
        chk(gp_in_a, pads);
        chk(pin_out_b, (sb & src_b) | (~sb & src_a));
        chk(pin_oe_b, (sb & src_a) | (~sb & src_b));
        chk(func_a_in_b, pads & ~sb);
        chk(func_b_in_b, pads & sb);
        chk(gp_in_b, pads);
        chk({31'h0, card_slot_b_data0}, {31'h0, pads[0] & sel[0]});
        chk({31'h0, serial_port0_master_in}, {31'h0, pads[0] & ~sel[0]});
        chk({31'h0, debug_serial_rx}, {31'h0, pads[14]});
    endtask : run_route
    // Back to plain I/O with set and clear together on line 0 of A, then clear line 0 alone
    task automatic run_io();
        cfg_periph_clr_a = 32'hFFFF_FFFF;
        cfg_periph_clr_b = 32'hFFFF_FFFF;
        cfg_periph_set_a = 32'h0000_0001;
        gp_out = 32'hC3A5_5A3C;
        gp_oe = 32'h0FF0_F00F;
        cfg_pullup = 32'h0F0F_00F0;
        cyc(1);
        cfg_periph_set_a = 32'h0;
        cfg_periph_clr_a = 32'h0;
        cfg_periph_clr_b = 32'h0;
        cyc(3);
        chk(peripheral_select_status_a, 32'h0000_0001);
        chk(peripheral_select_status_b, 32'h0);
        chk(pin_out_a, (gp_out & 32'hFFFF_FFFE) | (src_a & 32'h1));
        chk(pin_oe_a, (gp_oe & 32'hFFFF_FFFE) | (src_b & 32'h1));
        chk(pin_out_b, gp_out);
        chk(pin_oe_b, gp_oe);
        chk(pin_pullup_a, cfg_pullup);
        chk(pin_pullup_b, cfg_pullup);
        cfg_periph_clr_a = 32'h0000_0001;
        cyc(1);
        cfg_periph_clr_a = 32'h0;
        cyc(3);
        chk(peripheral_select_status_a, 32'h0);
        chk(pin_out_a, gp_out);
        chk({31'h0, serial_port0_master_in}, 32'h0);
    endtask : run_io
    initial begin
        {cfg_periph_set_a, cfg_periph_clr_a, cfg_sel_b_a, gp_out, gp_oe} = '0;
        {cfg_periph_set_b, cfg_periph_clr_b, cfg_sel_b_b} = '0;
        cfg_pullup = 32'hFFFF_FFFF;
        cyc(8);
        check_reset();
        rst_b = 1'b1;
        cyc(2);
        check_release();
        run_route(32'h5555_5555);
        run_route(32'hAAAA_AAAA);
        run_io();
        rst_b = 1'b0;
        cyc(1);
        check_reset();
        rst_b = 1'b1;
        cyc(2);
        check_release();
        give_verdict();
    end
endmodule : tb_io_line_peripheral_mux
